// ===== hdl/link_flow_ctl.sv
// Contract
// - Enhanced mode: four local credits per class, each its own counter.
// - Properly received packet consumes one local credit of its class.
// - Freed buffer: send one token, advance index A..D wrapping, add credit.
// - First generation: payload starts on good header then immediate start set.
// - First generation: valid end set completes the payload.
// - First generation: valid abort set aborts the payload.
// - First generation: stray control symbol aborts; its later end/abort ignored.
// - First generation: payload reaching babble limit without end/abort aborts.
// - First generation: drop payload of corrupted header or not following header.
// - Enhanced: start needs good header or valid length, then start/abort set.
// - Enhanced: end or abort set at length plus four completes payload.
// - Enhanced: no end/abort at that position aborts and requests Recovery.
// - Enhanced: abort set right after header counts as completed payload.
// - Keep every sent header until acknowledged by LGOOD_n.
// - Advertisement: flush headers up to n modulo 8, ACK becomes n+1.
// - Ordinary LGOOD_n: flush header n, ACK plus one modulo 8.
// - Ordinary LGOOD_n not matching ACK: Recovery, ACK unchanged.
// - Each received credit token adds one to matching remote counter.
// - Credit token index out of order in any class: Recovery.
// - LBAD: one LRTY then resend all unacknowledged headers, else LRTY alone.
// - Hub sets DL, regenerates CRC-5; payload dropped or nullified by mode.
// - Host/peripheral may set DL; retried header with DL clear keeps payload.
// - Proper header needs CRC-5, CRC-16, sequence match and a free buffer.
`timescale 1ns/100ps
`include "lfc_regs.svh"
module link_flow_ctl #(
    parameter logic [11:0] BABBLE = `LFC_BABBLE,
    parameter int          DEPTH  = 4
) (
    input  logic                   clock_i,
    input  logic                   reset_i,
    input  logic                   enh_i,
    input  logic                   hub_i,
    input  logic                   dl_opt_i,
    input  logic                   hdr_valid_i,
    input  lfc_pkg::rx_hdr_t       hdr_i,
    input  logic                   sym_valid_i,
    input  lfc_pkg::os_t           sym_i,
    input  logic                   free_valid_i,
    input  logic                   free_cls_i,
    input  logic                   sent_valid_i,
    input  lfc_pkg::hdr_t          sent_i,
    input  logic                   lgood_valid_i,
    input  logic [2:0]             lgood_n_i,
    input  logic                   adv_i,
    input  logic                   lcrd_valid_i,
    input  lfc_pkg::tok_t          lcrd_i,
    input  logic                   lbad_i,
    input  logic                   rec_enter_i,
    input  logic                   retry_ready_i,
    output logic                   hdr_ok_o,
    output logic                   pay_start_o,
    output logic                   pay_done_o,
    output logic                   pay_abort_o,
    output logic                   tok_valid_o,
    output lfc_pkg::tok_t          tok_o,
    output logic [1:0][2:0]        loc_cnt_o,
    output logic [1:0][2:0]        rem_cnt_o,
    output logic [2:0]             ack_seq_o,
    output logic                   lrty_o,
    output logic                   rec_req_o,
    output logic                   retry_valid_o,
    output lfc_pkg::retry_t        retry_o
);
    import lfc_pkg::*;

    typedef enum logic [1:0] {
        P_IDLE = 2'b00,
        P_WAIT = 2'b01,
        P_RUN  = 2'b10,
        P_SKIP = 2'b11
    } pst_t;

    function automatic logic [1:0] nxt_idx(input logic [1:0] i);
        return (i == `LFC_IDX_D) ? `LFC_IDX_A : i + 2'h1;
    endfunction

    // Whether s lies in the window from ack up to n, modulo 8
    function automatic logic in_win(input logic [2:0] s, input logic [2:0] a, input logic [2:0] n);
        return 3'(s - a) <= 3'(n - a);
    endfunction

    pst_t        st_r;
    pst_t        st_nxt;
    logic [11:0] pcnt_r;
    logic [11:0] pcnt_nxt;
    logic [11:0] pend_r;
    logic        halt_r;
    logic        act;
    logic        proper;
    logic        hp;
    logic        ps;
    logic        pd;
    logic        pa;
    logic        prec;
    logic        ack_rec;
    logic        crd_rec;
    logic        rec_cond;
    logic        lcls;
    logic        lcrd_ok;
    logic [1:0]  loc_idx_r [2];
    logic [1:0]  rem_idx_r [2];
    logic        ret_v_r [8];
    hdr_t        ret_d_r [8];
    logic        walk_r;
    logic [2:0]  wptr_r;
    logic [2:0]  wcnt_r;
    logic        fq_ready;
    logic        wstep;
    retry_t      wdata;

    // Headers, remote credits, LGOOD and LBAD freeze while Recovery is pending
    assign act    = !halt_r;
    assign hp     = hdr_valid_i && act;
    assign proper = hdr_i.crc5_ok && hdr_i.crc16_ok && hdr_i.seq_ok
                    && (loc_cnt_o[hdr_i.cls] != `LFC_CNT_ZERO);
    assign pcnt_nxt = pcnt_r + `LFC_POS_ONE;

    always_comb begin
        st_nxt = st_r;
        ps   = 1'b0;
        pd   = 1'b0;
        pa   = 1'b0;
        prec = 1'b0;
        if (hp) begin
            if (hdr_i.is_dp && (proper || (enh_i && hdr_i.len_ok))) begin
                st_nxt = P_WAIT;
            end else begin
                st_nxt = P_IDLE;
            end
        end else if (sym_valid_i) begin
            unique case (st_r)
                P_IDLE: begin
                    st_nxt = P_IDLE;
                end
                P_WAIT: begin
                    st_nxt = P_IDLE;
                    if (sym_i == OS_START) begin
                        st_nxt = P_RUN;
                        ps = 1'b1;
                    end else if (enh_i && sym_i == OS_ABORT) begin
                        pd = 1'b1;
                    end
                end
                P_RUN: begin
                    if (enh_i) begin
                        if (pcnt_r == pend_r) begin
                            st_nxt = P_IDLE;
                            if (sym_i == OS_END || sym_i == OS_ABORT) begin
                                pd = 1'b1;
                            end else begin
                                pa   = 1'b1;
                                prec = 1'b1;
                            end
                        end
                    end else if (sym_i == OS_END) begin
                        st_nxt = P_IDLE;
                        pd = 1'b1;
                    end else if (sym_i == OS_ABORT) begin
                        st_nxt = P_IDLE;
                        pa = 1'b1;
                    end else if (sym_i == OS_OTHERK || pcnt_nxt == BABBLE) begin
                        st_nxt = P_SKIP;
                        pa = 1'b1;
                    end
                end
                P_SKIP: begin
                    // Swallow the closing set of an already aborted payload
                    if (sym_i == OS_END || sym_i == OS_ABORT) begin
                        st_nxt = P_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            st_r        <= P_IDLE;
            pcnt_r      <= `LFC_POS_ZERO;
            pend_r      <= `LFC_POS_ZERO;
            pay_start_o <= 1'b0;
            pay_done_o  <= 1'b0;
            pay_abort_o <= 1'b0;
            hdr_ok_o    <= 1'b0;
        end else begin
            st_r        <= st_nxt;
            pay_start_o <= ps;
            pay_done_o  <= pd;
            pay_abort_o <= pa;
            hdr_ok_o    <= hp && proper;
            if (hp) begin
                pend_r <= {1'b0, hdr_i.len} + `LFC_END_OFS;
            end
            if (ps) begin
                pcnt_r <= `LFC_POS_ZERO;
            end else if (sym_valid_i && st_r == P_RUN) begin
                pcnt_r <= pcnt_nxt;
            end
        end
    end

    // Local credits and returned tokens
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            tok_valid_o <= 1'b0;
            tok_o       <= '0;
            for (int c = 0; c < 2; c++) begin
                loc_cnt_o[c] <= `LFC_CRED_NUM;
                loc_idx_r[c] <= `LFC_IDX_A;
            end
        end else begin
            tok_valid_o <= free_valid_i;
            tok_o       <= '{cls: free_cls_i, idx: loc_idx_r[free_cls_i]};
            for (int c = 0; c < 2; c++) begin
                if (free_valid_i && free_cls_i == 1'(c)) begin
                    loc_idx_r[c] <= nxt_idx(loc_idx_r[c]);
                end
                loc_cnt_o[c] <= loc_cnt_o[c]
                    - 3'(hp && proper && hdr_i.cls == 1'(c))
                    + 3'(free_valid_i && free_cls_i == 1'(c));
            end
        end
    end

    // Remote credits; the first generation only has class zero
    assign lcls    = enh_i && lcrd_i.cls;
    assign lcrd_ok = lcrd_i.idx == rem_idx_r[lcls];
    assign crd_rec = lcrd_valid_i && act && !lcrd_ok;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            for (int c = 0; c < 2; c++) begin
                rem_cnt_o[c] <= `LFC_CNT_ZERO;
                rem_idx_r[c] <= `LFC_IDX_A;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (lcrd_valid_i && act && lcrd_ok && lcls == 1'(c)) begin
                    rem_idx_r[c] <= nxt_idx(rem_idx_r[c]);
                end
                rem_cnt_o[c] <= rem_cnt_o[c]
                    + 3'(lcrd_valid_i && act && lcrd_ok && lcls == 1'(c))
                    - 3'(sent_valid_i && (enh_i && sent_i.cls) == 1'(c));
            end
        end
    end

    // Acknowledgement sequence and retained headers
    assign ack_rec = lgood_valid_i && act && !adv_i && lgood_n_i != ack_seq_o;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ack_seq_o <= `LFC_SEQ_ZERO;
        end else if (lgood_valid_i && act) begin
            if (adv_i) begin
                ack_seq_o <= lgood_n_i + `LFC_SEQ_ONE;
            end else if (lgood_n_i == ack_seq_o) begin
                ack_seq_o <= ack_seq_o + `LFC_SEQ_ONE;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            for (int s = 0; s < 8; s++) begin
                ret_v_r[s] <= 1'b0;
                ret_d_r[s] <= '0;
            end
        end else begin
            for (int s = 0; s < 8; s++) begin
                if (lgood_valid_i && act) begin
                    if (adv_i ? in_win(3'(s), ack_seq_o, lgood_n_i)
                              : (lgood_n_i == ack_seq_o && lgood_n_i == 3'(s))) begin
                        ret_v_r[s] <= 1'b0;
                    end
                end
                // New header wins over a flush of the same slot
                if (sent_valid_i && sent_i.seq == 3'(s)) begin
                    ret_v_r[s] <= 1'b1;
                    ret_d_r[s] <= sent_i;
                end
            end
        end
    end

    // Recovery request and freeze
    assign rec_cond = prec || ack_rec || crd_rec;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            halt_r    <= 1'b0;
            rec_req_o <= 1'b0;
        end else begin
            rec_req_o <= rec_cond && (!halt_r || rec_enter_i);
            if (rec_cond) begin
                halt_r <= 1'b1;
            end else if (rec_enter_i) begin
                halt_r <= 1'b0;
            end
        end
    end

    // Retry walk: LRTY first, then every still-retained header from ACK on
    assign wstep = walk_r && (fq_ready || !ret_v_r[wptr_r]);
    assign wdata = '{hdr: ret_d_r[wptr_r],
                     dl: hub_i || dl_opt_i,
                     drop_pay: hub_i && !enh_i && ret_d_r[wptr_r].is_dp,
                     null_pay: hub_i && enh_i && ret_d_r[wptr_r].is_dp};

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            lrty_o <= 1'b0;
            walk_r <= 1'b0;
            wptr_r <= `LFC_SEQ_ZERO;
            wcnt_r <= `LFC_SEQ_ZERO;
        end else begin
            lrty_o <= lbad_i && act && !walk_r;
            if (lbad_i && act && !walk_r) begin
                walk_r <= 1'b1;
                wptr_r <= ack_seq_o;
                wcnt_r <= `LFC_SEQ_ZERO;
            end else if (wstep) begin
                wptr_r <= wptr_r + `LFC_SEQ_ONE;
                wcnt_r <= wcnt_r + `LFC_SEQ_ONE;
                if (wcnt_r == `LFC_WALK_LAST) begin
                    walk_r <= 1'b0;
                end
            end
        end
    end

    // Retry stream stalls the walk when the framer holds off
    lfc_fifo #(
        .W     ($bits(retry_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .reset_i     (reset_i),
        .in_valid_i  (walk_r && ret_v_r[wptr_r]),
        .in_data_i   (wdata),
        .in_ready_o  (fq_ready),
        .out_valid_o (retry_valid_o),
        .out_data_o  (retry_o),
        .out_ready_i (retry_ready_i)
    );

    AST_CONSUME: assert property (@(posedge clock_i) disable iff (reset_i)
        hp && proper && !free_valid_i |=> loc_cnt_o[$past(hdr_i.cls)] == $past(loc_cnt_o[hdr_i.cls]) - 3'h1)
        else $error("local credit not consumed");
    AST_CRED_MAX: assert property (@(posedge clock_i) disable iff (reset_i)
        loc_cnt_o[0] <= `LFC_CRED_NUM && loc_cnt_o[1] <= `LFC_CRED_NUM)
        else $error("local credit above four");
    AST_TOKEN: assert property (@(posedge clock_i) disable iff (reset_i)
        free_valid_i |=> tok_valid_o && tok_o.cls == $past(free_cls_i)
        && tok_o.idx == $past(loc_idx_r[free_cls_i]))
        else $error("credit token missing");
    AST_ACK_INC: assert property (@(posedge clock_i) disable iff (reset_i)
        lgood_valid_i && act && !adv_i && lgood_n_i == ack_seq_o |=> ack_seq_o == $past(lgood_n_i) + 3'h1)
        else $error("ack sequence not advanced");
    AST_ACK_MISS: assert property (@(posedge clock_i) disable iff (reset_i)
        ack_rec |=> rec_req_o && $stable(ack_seq_o) ##1 !rec_req_o)
        else $error("lgood mismatch handled wrongly");
    AST_LRTY: assert property (@(posedge clock_i) disable iff (reset_i)
        lbad_i && act && !walk_r |=> lrty_o ##1 !lrty_o)
        else $error("single lrty not sent");
    AST_REM_INC: assert property (@(posedge clock_i) disable iff (reset_i)
        lcrd_valid_i && act && lcrd_ok && !sent_valid_i
        |=> rem_cnt_o[$past(lcls)] == $past(rem_cnt_o[lcls]) + 3'h1)
        else $error("remote credit not counted");
    AST_LCRD_ORDER: assert property (@(posedge clock_i) disable iff (reset_i)
        lcrd_valid_i && !halt_r && !lcrd_ok |=> rec_req_o)
        else $error("out of order credit missed");
    AST_ENH_END: assert property (@(posedge clock_i) disable iff (reset_i)
        enh_i && !hdr_valid_i && sym_valid_i && st_r == P_RUN && pcnt_r == pend_r
        && sym_i != OS_END && sym_i != OS_ABORT && !halt_r |=> pay_abort_o && rec_req_o)
        else $error("missing end set not aborted");
    AST_DL: assert property (@(posedge clock_i) disable iff (reset_i)
        retry_valid_o && hub_i && $stable(hub_i) |-> retry_o.dl)
        else $error("hub retry without dl");
endmodule

// ===== shared/lfc_regs.svh
`ifndef LFC_REGS_SVH
`define LFC_REGS_SVH

// Local credits per class after reset
`define LFC_CRED_NUM  3'h4
`define LFC_CNT_ZERO  3'h0
`define LFC_IDX_A     2'h0
`define LFC_IDX_D     2'h3
`define LFC_SEQ_ZERO  3'h0
`define LFC_SEQ_ONE   3'h1
`define LFC_WALK_LAST 3'h7
// End-set position past the length field
`define LFC_END_OFS   12'h004
`define LFC_POS_ZERO  12'h000
`define LFC_POS_ONE   12'h001
// Babble limit in payload symbols, plain default
`define LFC_BABBLE    12'h410

`endif

// ===== shared/lfc_pkg.sv
package lfc_pkg;

    typedef enum logic [2:0] {
        OS_DATA   = 3'b000,
        OS_START  = 3'b001,
        OS_END    = 3'b010,
        OS_ABORT  = 3'b011,
        OS_OTHERK = 3'b100
    } os_t;

    typedef struct packed {
        logic        crc5_ok;
        logic        crc16_ok;
        logic        seq_ok;
        logic        is_dp;
        logic        cls;
        logic        len_ok;
        logic [10:0] len;
    } rx_hdr_t;

    typedef struct packed {
        logic       cls;
        logic [1:0] idx;
    } tok_t;

    typedef struct packed {
        logic [31:0] word;
        logic [2:0]  seq;
        logic        cls;
        logic        is_dp;
    } hdr_t;

    typedef struct packed {
        hdr_t hdr;
        logic dl;
        logic drop_pay;
        logic null_pay;
    } retry_t;

endpackage

// ===== hdl/lfc_fifo.sv
`timescale 1ns/100ps
module lfc_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input  logic         clock_i,
    input  logic         reset_i,
    input  logic         in_valid_i,
    input  logic [W-1:0] in_data_i,
    output logic         in_ready_o,
    output logic         out_valid_o,
    output logic [W-1:0] out_data_o,
    input  logic         out_ready_i
);
    // Depth must be a power of two; pointers wrap naturally
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic          push;
    logic          pop;

    assign push = in_valid_i && in_ready_o;
    assign pop  = out_valid_o && out_ready_i;
    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data_o = mem[rp_r];

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wp_r] <= in_data_i;
        end
    end

    // Flags registered from the next count so they stay honest
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            wp_r        <= '0;
            rp_r        <= '0;
            cnt_r       <= '0;
            in_ready_o  <= 1'b1;
            out_valid_o <= 1'b0;
        end else begin
            if (push) begin
                wp_r <= wp_r + AW'(1);
            end
            if (pop) begin
                rp_r <= rp_r + AW'(1);
            end
            cnt_r       <= cnt_nxt;
            in_ready_o  <= cnt_nxt != (AW+1)'(DEPTH);
            out_valid_o <= cnt_nxt != '0;
        end
    end
endmodule

// ===== dv/lfc_partner.sv
`timescale 1ns/100ps
module lfc_partner (
    input  logic          clock_i,
    input  logic          slow_i,
    output logic          lcrd_valid_o,
    output lfc_pkg::tok_t lcrd_o,
    output logic          lgood_valid_o,
    output logic [2:0]    lgood_n_o,
    output logic          adv_o,
    output logic          lbad_o,
    output logic          retry_ready_o
);
    import lfc_pkg::*;
    logic [1:0] nxt_idx [2];
    logic [1:0] ph = 2'h0;
    // Slow consumer takes one retry in four cycles
    always @(posedge clock_i) ph <= ph + 2'h1;
    assign retry_ready_o = !slow_i || ph == 2'h0;
    initial begin
        lcrd_valid_o = 1'b0;
        lcrd_o = '0;
        lgood_valid_o = 1'b0;
        lgood_n_o = 3'h0;
        adv_o = 1'b0;
        lbad_o = 1'b0;
        restart();
    end
    task automatic restart();
        nxt_idx[0] = 2'h0;
        nxt_idx[1] = 2'h0;
    endtask
    // Skip jumps one index ahead to fake a lost token
    task automatic credit(input logic cls, input logic skip);
        @(negedge clock_i);
        lcrd_o = '{cls: cls, idx: nxt_idx[cls] + {1'b0, skip}};
        lcrd_valid_o = 1'b1;
        if (!skip) nxt_idx[cls] = nxt_idx[cls] + 2'h1;
        @(negedge clock_i);
        lcrd_valid_o = 1'b0;
        lcrd_o = tok_t'(~lcrd_o);
    endtask
    task automatic good(input logic [2:0] n, input logic adv);
        @(negedge clock_i);
        lgood_n_o = n;
        adv_o = adv;
        lgood_valid_o = 1'b1;
        @(negedge clock_i);
        lgood_valid_o = 1'b0;
        adv_o = 1'b0;
        lgood_n_o = ~n;
    endtask
    task automatic bad();
        @(negedge clock_i);
        lbad_o = 1'b1;
        @(negedge clock_i);
        lbad_o = 1'b0;
    endtask
endmodule

// ===== dv/tb_link_flow_ctl.sv
`timescale 1ns/100ps
module tb_link_flow_ctl;
    import lfc_pkg::*;
    localparam logic [11:0] BAB = 12'h010;
    logic            clock_i = 1'b0, reset_i = 1'b1, enh_i = 1'b1, hub_i = 1'b0, dl_opt_i = 1'b0;
    logic            slow = 1'b0, hdr_valid_i = 1'b0, sym_valid_i = 1'b0, free_valid_i = 1'b0;
    logic            free_cls_i = 1'b0, sent_valid_i = 1'b0, rec_enter_i = 1'b0;
    rx_hdr_t         hdr_i = '0;
    os_t             sym_i = OS_DATA;
    hdr_t            sent_i = '0;
    logic            lgood_valid_i, adv_i, lcrd_valid_i, lbad_i, retry_ready_i;
    logic [2:0]      lgood_n_i, ack_seq_o;
    tok_t            lcrd_i, tok_o;
    logic            hdr_ok_o, pay_start_o, pay_done_o, pay_abort_o, tok_valid_o;
    logic            lrty_o, rec_req_o, retry_valid_o;
    logic [1:0][2:0] loc_cnt_o, rem_cnt_o;
    retry_t          retry_o;
    retry_t          got[$];
    logic [1:0]      eidx [2];
    int              nlrty, error_cnt = 0, checked = 0;

    always #50 clock_i = ~clock_i;
    link_flow_ctl #(.BABBLE(BAB)) link_flow_ctl_i (.*);
    lfc_partner lfc_partner_i (.clock_i(clock_i), .slow_i(slow), .lcrd_valid_o(lcrd_valid_i),
        .lcrd_o(lcrd_i), .lgood_valid_o(lgood_valid_i), .lgood_n_o(lgood_n_i), .adv_o(adv_i),
        .lbad_o(lbad_i), .retry_ready_o(retry_ready_i));

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("Counts: %0d checks, %0d mismatches", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic tick();
        @(negedge clock_i);
    endtask
    function automatic rx_hdr_t mk(logic ok, logic dp, logic c, logic [10:0] len);
        return '{ok, 1'b1, 1'b1, dp, c, 1'b1, len};
    endfunction
    task automatic hdr(rx_hdr_t h, logic exp);
        tick();
        hdr_i = h;
        hdr_valid_i = 1'b1;
        tick();
        hdr_valid_i = 1'b0;
        hdr_i = rx_hdr_t'(~h);
        check("hdr_ok", hdr_ok_o, exp);
    endtask
    task automatic sym_only(os_t s);
        tick();
        sym_i = s;
        sym_valid_i = 1'b1;
        tick();
        sym_valid_i = 1'b0;
        sym_i = os_t'(~s);
    endtask
    // Expected order: start, done, abort, recovery request
    task automatic sym(os_t s, logic [3:0] e);
        sym_only(s);
        check("payload", {pay_start_o, pay_done_o, pay_abort_o, rec_req_o}, e);
    endtask
    task automatic free(logic c);
        tick();
        free_cls_i = c;
        free_valid_i = 1'b1;
        tick();
        free_valid_i = 1'b0;
        free_cls_i = ~c;
        check("token", {tok_valid_o, tok_o}, {1'b1, c, eidx[c]});
        eidx[c] = eidx[c] + 2'h1;
    endtask
    task automatic enter();
        rec_enter_i = 1'b1;
        tick();
        rec_enter_i = 1'b0;
    endtask
    task automatic sent(logic [2:0] s);
        tick();
        sent_i = '{word: 32'ha5a5_0000, seq: s, cls: 1'b0, is_dp: 1'b1};
        sent_valid_i = 1'b1;
        tick();
        sent_valid_i = 1'b0;
        sent_i = hdr_t'(~sent_i);
    endtask
    // Observation window covers the full eight-slot walk with stalls
    task automatic collect();
        got.delete();
        nlrty = 0;
        repeat (60) begin
            tick();
            nlrty += int'(lrty_o);
            if (retry_valid_o && retry_ready_i) got.push_back(retry_o);
        end
    endtask
    task automatic do_reset(logic m, logic hub);
        reset_i = 1'b1;
        enh_i = m;
        hub_i = hub;
        repeat (12) tick();
        reset_i = 1'b0;
        eidx[0] = 2'h0;
        eidx[1] = 2'h0;
        lfc_partner_i.restart();
        tick();
        check("loc_cnt", loc_cnt_o, 6'h24);
        check("rem_ack", {rem_cnt_o, ack_seq_o}, 9'h000);
    endtask

    task automatic t_credits();
        hdr(mk(1'b0, 1'b0, 1'b1, 11'h000), 1'b0);
        check("loc_bad", loc_cnt_o, 6'h24);
        for (int i = 0; i < 5; i++) begin
            hdr(mk(1'b1, 1'b0, 1'b1, 11'h000), 1'b1);
            check("loc_take", loc_cnt_o, 6'h1c);
            free(1'b1);
            check("loc_back", loc_cnt_o, 6'h24);
        end
        $display("test credits done");
    endtask
    task automatic t_enh_payload();
        hdr(mk(1'b1, 1'b1, 1'b0, 11'h002), 1'b1);
        sym(OS_START, 4'h8);
        repeat (6) sym(OS_DATA, 4'h0);
        sym(OS_END, 4'h4);
        hdr(mk(1'b0, 1'b1, 1'b0, 11'h000), 1'b0);
        sym(OS_START, 4'h8);
        repeat (4) sym(OS_DATA, 4'h0);
        sym(OS_ABORT, 4'h4);
        hdr(mk(1'b1, 1'b1, 1'b0, 11'h000), 1'b1);
        sym(OS_ABORT, 4'h4);
        hdr(mk(1'b1, 1'b1, 1'b0, 11'h000), 1'b1);
        sym(OS_START, 4'h8);
        repeat (4) sym(OS_DATA, 4'h0);
        sym(OS_DATA, 4'h3);
        hdr(mk(1'b1, 1'b1, 1'b0, 11'h000), 1'b0);
        enter();
        repeat (3) free(1'b0);
        $display("test enhanced payload done");
    endtask
    task automatic t_enh_retry();
        sent(3'h0);
        lfc_partner_i.bad();
        check("lrty", lrty_o, 1'b1);
        collect();
        check("retry_cnt", got.size(), 1);
        check("retry_dl", {got[0].dl, got[0].drop_pay, got[0].null_pay}, 3'h0);
        dl_opt_i = 1'b1;
        lfc_partner_i.bad();
        collect();
        check("retry_opt", {got[0].dl, got[0].drop_pay, got[0].null_pay}, 3'h4);
        hub_i = 1'b1;
        lfc_partner_i.bad();
        collect();
        check("retry_hub", {got[0].dl, got[0].drop_pay, got[0].null_pay}, 3'h5);
        {hub_i, dl_opt_i} = 2'b00;
        lfc_partner_i.good(3'h0, 1'b0);
        $display("test enhanced retry done");
    endtask
    task automatic t_gen1_payload();
        int na;
        na = 0;
        hdr(mk(1'b1, 1'b1, 1'b0, 11'h000), 1'b1);
        sym(OS_START, 4'h8);
        sym(OS_DATA, 4'h0);
        sym(OS_END, 4'h4);
        hdr(mk(1'b1, 1'b1, 1'b0, 11'h000), 1'b1);
        sym(OS_START, 4'h8);
        sym(OS_ABORT, 4'h2);
        hdr(mk(1'b1, 1'b1, 1'b0, 11'h000), 1'b1);
        sym(OS_START, 4'h8);
        sym(OS_OTHERK, 4'h2);
        sym(OS_END, 4'h0);
        repeat (3) free(1'b0);
        hdr(mk(1'b1, 1'b1, 1'b0, 11'h000), 1'b1);
        sym(OS_START, 4'h8);
        repeat (20) begin
            sym_only(OS_DATA);
            na += int'(pay_abort_o);
        end
        check("babble", na, 1);
        sym(OS_END, 4'h0);
        hdr(mk(1'b0, 1'b1, 1'b0, 11'h000), 1'b0);
        sym(OS_START, 4'h0);
        sym(OS_END, 4'h0);
        hdr(mk(1'b1, 1'b1, 1'b0, 11'h000), 1'b1);
        sym(OS_DATA, 4'h0);
        sym(OS_START, 4'h0);
        sym(OS_END, 4'h0);
        repeat (2) free(1'b0);
        $display("test first generation payload done");
    endtask
    task automatic t_ack_retry();
        for (int i = 1; i < 4; i++) begin
            lfc_partner_i.credit(1'b0, 1'b0);
            check("rem_cnt", rem_cnt_o[0], 3'(i));
        end
        lfc_partner_i.credit(1'b0, 1'b1);
        check("crd_order", {rec_req_o, rem_cnt_o[0]}, 4'hb);
        enter();
        for (int i = 0; i < 3; i++) sent(3'(i));
        lfc_partner_i.good(3'h0, 1'b0);
        check("ack", ack_seq_o, 3'h1);
        lfc_partner_i.good(3'h5, 1'b0);
        check("ack_bad", {rec_req_o, ack_seq_o}, 4'h9);
        enter();
        slow = 1'b1;
        lfc_partner_i.bad();
        check("lrty", lrty_o, 1'b1);
        collect();
        check("lrty_once", nlrty, 0);
        check("retry_cnt", got.size(), 2);
        for (int i = 0; i < 2; i++) begin
            check("retry_seq", got[i].hdr.seq, 3'(i + 1));
            check("retry_dl", {got[i].dl, got[i].drop_pay, got[i].null_pay}, 3'h6);
        end
        lfc_partner_i.good(3'h2, 1'b1);
        check("ack_adv", ack_seq_o, 3'h3);
        lfc_partner_i.bad();
        check("lrty", lrty_o, 1'b1);
        collect();
        check("retry_none", got.size(), 0);
        $display("test acknowledge and retry done");
    endtask

    initial begin
        repeat (100000) @(posedge clock_i);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        do_reset(1'b1, 1'b0);
        t_credits();
        t_enh_payload();
        t_enh_retry();
        do_reset(1'b0, 1'b1);
        t_gen1_payload();
        t_ack_retry();
        tally_and_finish();
    end
endmodule
